// ### inc/mem_lock_pkg.sv
// Purpose: Shared constants and types for the debug port memory lock block
// Assumes: One system clock, asynchronous active-low reset
// Notes: Memory sections are coded so both access ports share one decoder
package mem_lock_pkg;
   localparam logic [31:0] UNLOCK_KEY = 32'h5CC5_C55C;
   localparam logic [31:0] KEY_RESET = 32'h5CC5_C55C;
   localparam logic [7:0] PROTECTION_KEY_OFFSET = 8'h00;
   localparam logic [31:0] INVALID_DATA = 32'h0000_0000;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   typedef enum logic [2:0] {
      SEC_FLASH = 3'b000,
      SEC_SRAM = 3'b001,
      SEC_EEPROM = 3'b010,
      SEC_SIGNATURE_ROW = 3'b011,
      SEC_USER_ROW_A = 3'b100,
      SEC_FUSE = 3'b101,
      SEC_LOCK = 3'b110,
      SEC_REGS = 3'b111
   } section_e;

   typedef enum logic [1:0] {
      ERASE_IDLE = 2'b00,
      ERASE_BUSY = 2'b01,
      ERASE_DONE = 2'b10
   } erase_state_e;

   typedef struct packed {
      logic valid;
      logic write;
      logic fuse_write_cmd;
      section_e section;
      logic [31:0] wdata;
   } access_req_s;

   typedef struct packed {
      logic read_ok;
      logic write_ok;
   } access_grant_s;

   localparam logic [7:0] ERASE_CYCLES = 8'd16;
endpackage

// ### logic/access_decide.sv
// Purpose: Decides whether a port may read or write one memory section
// Assumes: Combinational, shared by the debug and CPU paths
// Notes: CPU answer ignores lock state
`timescale 1ns/1ns
`default_nettype none
module access_decide
   import mem_lock_pkg::*;
(
   // Request
   input wire logic from_debug,
   input wire logic unlocked,
   input wire logic fuse_write_cmd,
   input wire section_e section,
   // Answer
   output access_grant_s grant
);
   always_comb begin
      grant = '0;
      if (!from_debug) begin
         grant.read_ok = 1'b1; // see RULE5
         grant.write_ok = !(section inside {SEC_SIGNATURE_ROW, SEC_FUSE, SEC_LOCK}); // see RULE5
      end else if (unlocked) begin
         grant.read_ok = 1'b1; // see RULE6
         grant.write_ok = (section != SEC_SIGNATURE_ROW); // see RULE6
      end else begin
         grant.read_ok = 1'b0; // see RULE4 see RULE7
         grant.write_ok = (section == SEC_USER_ROW_A) && fuse_write_cmd; // see RULE7 see RULE8
      end
   end
endmodule
`default_nettype wire

// ### logic/debug_port_memory_lock.sv
// Purpose: Gates debug port access to memory sections by the lock key; CPU access ignores lock state
// Assumes: Memory arrays sit outside; this block forwards granted accesses
// Notes: The CPU wins the shared memory path; a debug request in that cycle
//    gets no answer and must be held until it does.
//    During a full chip erase every access is answered refused.
//    Key reads are served here, never from the memory side.
// Contract
// RULE1: Unlocked only while key equals unlock value
// RULE2: Debugger locks by writing any other key
// RULE3: Key ships unlocked, read-only to CPU
// RULE4: Locked debug reads of memories are refused
// RULE5: CPU access same whether locked or not
// RULE6: Unlocked debug writes all except signature row
// RULE7: Locked debug: no reads, only user-row writes
// RULE8: Locked user-row write via fuse-write command only
// RULE9: Blocked read completes with invalid data
// RULE10: Only full chip erase leaves locked state; reset also loads the unlock key
// RULE11: Erase completion restores the unlock key
`timescale 1ns/1ns
`default_nettype none
module debug_port_memory_lock
   import mem_lock_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Debug port access
   input wire access_req_s dbg_req,
   input wire logic full_chip_erase_cmd,
   output logic dbg_done,
   output logic dbg_granted,
   output logic [31:0] dbg_rdata,
   // CPU access
   input wire access_req_s cpu_req,
   output logic cpu_done,
   output logic cpu_granted,
   output logic [31:0] cpu_rdata,
   // Memory side
   output logic mem_valid,
   output logic mem_write,
   output section_e mem_section,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   output logic mem_erase_all,
   // Status
   output logic unlocked,
   output logic erase_busy
);
   logic [31:0] protection_key;
   logic [31:0] next_protection_key;
   erase_state_e erase_state;
   erase_state_e next_erase_state;
   logic [7:0] erase_count;
   logic [7:0] next_erase_count;
   logic next_dbg_done;
   logic next_dbg_granted;
   logic [31:0] next_dbg_rdata;
   logic next_cpu_done;
   logic next_cpu_granted;
   logic [31:0] next_cpu_rdata;
   access_grant_s dbg_grant;
   access_grant_s cpu_grant;
   logic dbg_ok;
   logic cpu_ok;
   logic cpu_sel;
   logic key_write;

   function automatic logic allowed(input access_req_s r, input access_grant_s g);
      allowed = r.write ? g.write_ok : g.read_ok;
   endfunction

   // The key lives in this block, not behind the memory port
   function automatic logic is_key_section(input section_e s);
      is_key_section = (s == SEC_LOCK);
   endfunction

   function automatic logic [31:0] read_value(input section_e s, input logic [31:0] key,
      input logic [31:0] mem);
      read_value = is_key_section(s) ? key : mem;
   endfunction

   access_decide u_dbg_decide (
      .from_debug(1'b1),
      .unlocked(unlocked),
      .fuse_write_cmd(dbg_req.fuse_write_cmd),
      .section(dbg_req.section),
      .grant(dbg_grant)
   );

   access_decide u_cpu_decide (
      .from_debug(1'b0),
      .unlocked(unlocked),
      .fuse_write_cmd(cpu_req.fuse_write_cmd),
      .section(cpu_req.section),
      .grant(cpu_grant)
   );

   assign unlocked = (protection_key == UNLOCK_KEY); // see RULE1
   assign erase_busy = (erase_state == ERASE_BUSY);
   assign mem_erase_all = erase_busy; // see RULE10

   // CPU has priority on the shared memory path; no access during erase
   assign cpu_ok = cpu_req.valid && !erase_busy && allowed(cpu_req, cpu_grant);
   assign dbg_ok = dbg_req.valid && !erase_busy && !cpu_req.valid && allowed(dbg_req, dbg_grant);
   assign cpu_sel = cpu_req.valid;
   // Key writable only from the debug port and only while no erase runs
   assign key_write = dbg_ok && dbg_req.write && is_key_section(dbg_req.section) && (erase_state == ERASE_IDLE);

   // Memory side follows the port that won; key accesses stay here
   always_comb begin
      mem_valid = 1'b0;
      if (cpu_ok) begin
         mem_valid = !is_key_section(cpu_req.section);
      end else if (dbg_ok) begin
         mem_valid = !is_key_section(dbg_req.section);
      end
      mem_write = cpu_sel ? cpu_req.write : dbg_req.write;
      mem_section = cpu_sel ? cpu_req.section : dbg_req.section;
      mem_wdata = cpu_sel ? cpu_req.wdata : dbg_req.wdata;
   end

   // Erase: a command in idle starts a fixed run, then one cycle restores the key
   always_comb begin
      next_erase_state = erase_state;
      next_erase_count = erase_count;
      case (erase_state)
         ERASE_IDLE: begin
            if (full_chip_erase_cmd) begin // see RULE10
               next_erase_state = ERASE_BUSY;
               next_erase_count = ERASE_CYCLES;
            end
         end
         ERASE_BUSY: begin
            next_erase_count = erase_count - 8'd1;
            if (erase_count == 8'd1) begin
               next_erase_state = ERASE_DONE;
            end
         end
         ERASE_DONE: begin
            next_erase_state = ERASE_IDLE;
         end
         default: begin
            next_erase_state = ERASE_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         erase_state <= ERASE_IDLE;
         erase_count <= 8'h00;
      end else begin
         erase_state <= next_erase_state;
         erase_count <= next_erase_count;
      end
   end

   // Key: restore and debug write never meet, a key write outside idle is dropped
   always_comb begin
      next_protection_key = protection_key;
      if (erase_state == ERASE_DONE) begin
         next_protection_key = UNLOCK_KEY; // see RULE11
      end else if (key_write) begin
         next_protection_key = dbg_req.wdata; // see RULE2 see RULE3
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         protection_key <= KEY_RESET; // see RULE3
      end else begin
         protection_key <= next_protection_key;
      end
   end

   // CPU answer, registered on the taking edge
   always_comb begin
      next_cpu_done = 1'b0;
      next_cpu_granted = 1'b0;
      next_cpu_rdata = INVALID_DATA;
      if (cpu_req.valid) begin
         next_cpu_done = 1'b1;
         next_cpu_granted = cpu_ok;
         if (cpu_ok && !cpu_req.write) begin
            next_cpu_rdata = read_value(cpu_req.section, protection_key, mem_rdata); // see RULE3
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cpu_done <= 1'b0;
         cpu_granted <= 1'b0;
         cpu_rdata <= INVALID_DATA;
      end else begin
         cpu_done <= next_cpu_done;
         cpu_granted <= next_cpu_granted;
         cpu_rdata <= next_cpu_rdata;
      end
   end

   // Debug answer; a request lost to the CPU gets no answer that cycle
   always_comb begin
      next_dbg_done = 1'b0;
      next_dbg_granted = 1'b0;
      next_dbg_rdata = INVALID_DATA; // see RULE9
      if (dbg_req.valid && !cpu_req.valid) begin
         next_dbg_done = 1'b1;
         next_dbg_granted = dbg_ok;
         if (dbg_ok && !dbg_req.write) begin
            next_dbg_rdata = read_value(dbg_req.section, protection_key, mem_rdata);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dbg_done <= 1'b0;
         dbg_granted <= 1'b0;
         dbg_rdata <= INVALID_DATA;
      end else begin
         dbg_done <= next_dbg_done;
         dbg_granted <= next_dbg_granted;
         dbg_rdata <= next_dbg_rdata;
      end
   end
endmodule
`default_nettype wire

// ### test/debug_port_memory_lock_checker.sv
// Purpose: Port-level checks of the memory lock block
// Assumes: One clock domain
// Notes: Attached by bind
`timescale 1ns/1ns
`default_nettype none
module debug_port_memory_lock_checker
   import mem_lock_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Watched signals
   input wire access_req_s dbg_req,
   input wire access_req_s cpu_req,
   input wire logic full_chip_erase_cmd,
   input wire logic dbg_done,
   input wire logic dbg_granted,
   input wire logic [31:0] dbg_rdata,
   input wire logic cpu_done,
   input wire logic cpu_granted,
   input wire logic mem_valid,
   input wire logic unlocked,
   input wire logic erase_busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic solo;
   assign solo = dbg_req.valid && !cpu_req.valid && !erase_busy;
   sequence erase_run;
      erase_busy [*8] ##1 erase_busy [*8];
   endsequence
   AST_KEY_RST: assert property ($rose(arst_n) |-> unlocked) else $error("not unlocked after reset");
   AST_KEY_RD: assert property (solo && !dbg_req.write && dbg_req.section == SEC_LOCK && unlocked
      |=> dbg_rdata == UNLOCK_KEY) else $error("key read wrong");
   AST_LOCK_RD: assert property (solo && !dbg_req.write && !unlocked
      |=> dbg_done && !dbg_granted && dbg_rdata == 32'h0000_0000) else $error("locked read leaked");
   AST_CPU_RD: assert property (cpu_req.valid && !cpu_req.write && !erase_busy
      |=> cpu_done && cpu_granted) else $error("cpu read refused");
   AST_UR_WR: assert property (solo && !unlocked && dbg_req.write && dbg_req.fuse_write_cmd
      && dbg_req.section == SEC_USER_ROW_A |=> dbg_granted) else $error("user row write refused");
   AST_SIG_WR: assert property (solo && dbg_req.write && dbg_req.section == SEC_SIGNATURE_ROW
      |=> dbg_done && !dbg_granted) else $error("signature write allowed");
   AST_ERASE: assert property ($rose(full_chip_erase_cmd) && !erase_busy
      |=> erase_run ##1 !erase_busy ##1 unlocked) else $error("erase sequence wrong");
   AST_LOCK_NOMEM: assert property (!unlocked && dbg_req.valid && !dbg_req.fuse_write_cmd && !cpu_req.valid
      |-> !mem_valid) else $error("locked access forwarded");
   AST_ERASE_NOMEM: assert property (erase_busy |-> !mem_valid) else $error("access forwarded during erase");
endmodule
bind debug_port_memory_lock debug_port_memory_lock_checker debug_port_memory_lock_checker_i (.*);
`default_nettype wire

// ### test/mem_model.sv
// Purpose: Memory arrays behind the lock block
// Assumes: Read data answers in the same cycle
// Notes: Unselected reads return a toggling pattern
`timescale 1ns/1ns
`default_nettype none
module mem_model
   import mem_lock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire section_e mem_section,
   output logic [31:0] mem_rdata
);
   logic [31:0] junk = 32'h0F0F_0F0F;
   always @(posedge clk_sys) junk <= ~junk;
   assign mem_rdata = (mem_valid && !mem_write) ? {16'hA5A5, 13'h0000, mem_section} : junk;
endmodule
`default_nettype wire

// ### test/test_debug_port_memory_lock.sv
// Purpose: Self-checking bench of the memory lock block
// Assumes: Inputs change at the falling edge
// Notes: Sweeps every section in both lock states
`timescale 1ns/1ns
`default_nettype none
module test_debug_port_memory_lock;
   import mem_lock_pkg::*;
   logic clk_sys, arst_n, cmd, dd, dg, cd, cg, mv, mw, ul, eb, ea;
   access_req_s dreq, creq;
   logic [31:0] dr, cr, mr, mwd;
   section_e ms, s;
   int bad_count = 0, checked = 0;
   debug_port_memory_lock debug_port_memory_lock_i (.clk_sys(clk_sys), .arst_n(arst_n), .dbg_req(dreq),
      .full_chip_erase_cmd(cmd), .dbg_done(dd), .dbg_granted(dg), .dbg_rdata(dr), .cpu_req(creq),
      .cpu_done(cd), .cpu_granted(cg), .cpu_rdata(cr), .mem_valid(mv), .mem_write(mw), .mem_section(ms),
      .mem_wdata(mwd), .mem_rdata(mr), .mem_erase_all(ea), .unlocked(ul), .erase_busy(eb));
   mem_model mem_model_i (.clk_sys(clk_sys), .mem_valid(mv), .mem_write(mw), .mem_section(ms), .mem_rdata(mr));
   function automatic logic [31:0] pat(input section_e x);
      return {16'hA5A5, 13'h0000, x};
   endfunction
   task automatic fail(input string m);
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic acc(input logic c, w, f, input section_e x, input logic [31:0] wd, input logic eg,
      input logic [31:0] er);
      access_req_s r;
      r = '{1'b1, w, f, x, wd};
      if (c) begin
         creq = r;
         dreq = '0;
      end else begin
         dreq = r;
         creq = '0;
      end
      @(negedge clk_sys);
      checked++;
      if ((c ? cd : dd) !== 1'b1 || (c ? cg : dg) !== eg || (c ? cr : dr) !== er) fail("access answer");
      checked++;
      if (mv !== (eg && x != SEC_LOCK) || mw !== w || mwd !== wd) fail("memory forward");
   endtask
   task automatic tally_and_finish;
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #50000;
      fail("watchdog");
      tally_and_finish;
   end
   initial begin
      arst_n = 0;
      cmd = 0;
      dreq = '0;
      creq = '0;
      repeat (6) @(negedge clk_sys);
      arst_n = 1;
      checked++;
      if (ul !== 1'b1) fail("reset key");
      $display("reset test done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 8; i++) begin
            s = section_e'(i);
            acc(1, 0, 0, s, 0, 1, s == SEC_LOCK ? (k ? 32'h0000_0000 : UNLOCK_KEY) : pat(s));
            acc(1, 1, 0, s, 32'h1234_5678, !(s inside {SEC_SIGNATURE_ROW, SEC_FUSE, SEC_LOCK}), 0);
            acc(0, 0, 0, s, 0, !k, k ? 32'h0000_0000 : (s == SEC_LOCK ? UNLOCK_KEY : pat(s)));
            acc(0, 1, k, s, UNLOCK_KEY, k ? s == SEC_USER_ROW_A : s != SEC_SIGNATURE_ROW, 0);
         end
         if (k == 0) begin
            acc(0, 1, 0, SEC_LOCK, 32'h0000_0000, 1, 0);
            checked++;
            if (ul !== 1'b0) fail("lock write");
         end else acc(0, 1, 0, SEC_USER_ROW_A, 0, 0, 0);
         $display("sweep %0d done", k);
      end
      dreq = '0;
      cmd = 1;
      @(negedge clk_sys);
      cmd = 0;
      acc(0, 0, 0, SEC_FLASH, 0, 0, 0);
      checked++;
      if (eb !== 1'b1 || ea !== 1'b1 || ul !== 1'b0) fail("erase start");
      acc(1, 0, 0, SEC_SRAM, 0, 0, 0);
      creq = '0;
      repeat (18) @(negedge clk_sys);
      checked++;
      if (ul !== 1'b1 || eb !== 1'b0 || ea !== 1'b0) fail("erase unlock");
      acc(0, 0, 0, SEC_FLASH, 0, 1, pat(SEC_FLASH));
      $display("erase test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
